// File: lrtm_consts.svh
// constants for the limit switch and temperature monitor
`ifndef LRTM_CONSTS_SVH
`define LRTM_CONSTS_SVH

// parameter addresses
`define ADDR_REF_EVAL 16'h061c
`define ADDR_LNEG_EVAL 16'h061e
`define ADDR_LPOS_EVAL 16'h0620
`define ADDR_MOT_MAX 16'h0d20
`define ADDR_AMP_WARN 16'h100c
`define ADDR_AMP_MAX 16'h100e
`define ADDR_AMP_NOW 16'h1c20
`define ADDR_MOT_NOW 16'h1c22
`define ADDR_DEV_NOW 16'h1c24

// evaluation settings and reset value
`define EVAL_OFF 16'h0000
`define EVAL_NC 16'h0001
`define EVAL_NO 16'h0002
`define EVAL_RESET 16'h0001

// fixed temperature limits in degrees celsius
`define MOT_MAX_T 16'h006e
`define MOT_WARN_T 16'h0064
`define AMP_MAX_T 16'h005a
`define AMP_WARN_T 16'h0050
`define RES_MAX_T 16'h0078
`define RES_WARN_T 16'h006e

// overtemperature delay and clock rate
`define OVT_TIME_S 32'd5
`define CLK_HZ 32'd250000000

// channel indices and misc
`define CH_MOT 0
`define CH_AMP 1
`define CH_RES 2
`define NUM_CH 3
`define SW_NEG 0
`define SW_POS 1
`define SW_REF 2
`define ZERO16 16'h0000
`define CNT_ONE 32'h00000001
`define CNT_ZERO 32'h00000000

`endif

// File: lrtm_far_side.sv
// switch contacts wired to the drive's three switch pins
`timescale 1ns/100ps
module lrtm_far_side (
	// contact actuation
	input wire logic act_neg,
	input wire logic act_pos,
	input wire logic act_ref,
	// contact kind per switch, high for normally open
	input wire logic [2:0] no_kind,
	// pin levels seen by the drive
	output logic neg_pin,
	output logic pos_pin,
	output logic ref_pin
);
	// closed contact pulls the pin high, an open one leaves it low
	assign neg_pin = no_kind[0] ? act_neg : !act_neg;
	assign pos_pin = no_kind[1] ? act_pos : !act_pos;
	assign ref_pin = no_kind[2] ? act_ref : !act_ref;
endmodule

// File: lrtm_pkg.sv
// types for the limit switch and temperature monitor
package lrtm_pkg;
	typedef enum logic [1:0] {
		LRTM_COOL = 2'h0,
		LRTM_WARM = 2'h1,
		LRTM_HOT = 2'h2,
		LRTM_TRIPPED = 2'h3
	} lrtm_chan_st_t;
endpackage

// File: lrtm_temp_chan.sv
// one supervised temperature with warning and delayed trip
`timescale 1ns/100ps
`include "lrtm_consts.svh"
module lrtm_temp_chan
	import lrtm_pkg::*;
#(
	parameter int unsigned OVT_CYCLES = 32'd1250000000
) (
	input wire logic clk,
	input wire logic rst,
	lrtm_temp_if.chan tch
);
	lrtm_chan_st_t st_reg, st_next;
	logic [31:0] cnt_reg, cnt_next;
	logic warn_reg, warn_next;
	logic over, near;

	// compare against the fixed limits
	assign over = tch.temp > tch.max_lim;
	assign near = tch.temp >= tch.warn_lim;

	// next state of the channel
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		case (st_reg)
			LRTM_TRIPPED: begin
				cnt_next = cnt_reg; // latched until reset
			end
			default: begin
				if (!over) begin
					cnt_next = `CNT_ZERO;
					st_next = near ? LRTM_WARM : LRTM_COOL;
				end else if (cnt_reg == OVT_CYCLES[31:0]) begin
					st_next = LRTM_TRIPPED;
				end else begin
					cnt_next = cnt_reg + `CNT_ONE;
					st_next = LRTM_HOT;
				end
			end
		endcase
		warn_next = near || over || (st_reg == LRTM_TRIPPED);
	end

	// register the channel state
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= LRTM_COOL;
			cnt_reg <= `CNT_ZERO;
			warn_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			warn_reg <= warn_next;
		end
	end

	assign tch.warn = warn_reg;
	assign tch.trip = (st_reg == LRTM_TRIPPED);

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_CNT_RESTART: assert property (
		(!over && st_reg != LRTM_TRIPPED) |=> cnt_reg == `CNT_ZERO)
		else $error("overtemperature timer not restarted");
	AST_TRIP_CAUSE: assert property (
		$rose(tch.trip) |-> $past(over)
		&& $past(cnt_reg) == OVT_CYCLES[31:0])
		else $error("trip without full overtemperature delay");
	AST_WARN_NEAR: assert property (
		near |=> tch.warn)
		else $error("no warning near the limit");
	AST_TRIP_HOLD: assert property (
		tch.trip |=> tch.trip && tch.warn)
		else $error("trip not held");
	COV_TRIP: cover property ($rose(tch.trip));
	COV_RESTART: cover property (st_reg == LRTM_HOT ##1 !over);
endmodule

// File: lrtm_temp_if.sv
// carrier between the top and one temperature channel
`timescale 1ns/100ps
interface lrtm_temp_if;
	logic signed [15:0] temp;
	logic signed [15:0] warn_lim;
	logic signed [15:0] max_lim;
	logic warn;
	logic trip;
	modport chan (input temp, input warn_lim, input max_lim,
		output warn, output trip);
	modport mon (output temp, output warn_lim, output max_lim,
		input warn, input trip);
endinterface

// File: lrtm_top.sv
// limit and reference switch evaluation with temperature supervision
`timescale 1ns/100ps
`include "lrtm_consts.svh"
module lrtm_top
	import lrtm_pkg::*;
#(
	parameter int unsigned OVT_CYCLES = `OVT_TIME_S * `CLK_HZ
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// switch pins
	input wire logic NEGATIVE_TRAVEL_SWITCH,
	input wire logic POSITIVE_TRAVEL_SWITCH,
	input wire logic REFERENCE_SWITCH,
	// motion state
	input wire logic HOMING_TO_REF,
	// temperature readings
	input wire logic signed [15:0] TEMP_MOTOR,
	input wire logic signed [15:0] TEMP_AMP,
	input wire logic signed [15:0] TEMP_RESISTOR,
	input wire logic signed [15:0] TEMP_DEVICE,
	input wire logic MOTOR_SENSOR_KIND,
	// parameter access
	input wire logic [15:0] PAR_ADDR,
	input wire logic PAR_WR,
	input wire logic PAR_RD,
	input wire logic [15:0] PAR_WDATA,
	output logic [15:0] PAR_RDATA,
	output logic PAR_ACK,
	// switch results
	output logic NEG_LIMIT_HIT,
	output logic POS_LIMIT_HIT,
	output logic REF_HIT,
	output logic STOP_MOTOR,
	// temperature results
	output logic TEMP_WARN,
	output logic TEMP_ERR,
	output logic AMP_OFF,
	output logic CTRL_OFF
);
	logic [2:0] sw_meta_reg, sw_sync_reg;
	logic [15:0] ref_eval_reg, ref_eval_next;
	logic [15:0] lneg_eval_reg, lneg_eval_next;
	logic [15:0] lpos_eval_reg, lpos_eval_next;
	logic [15:0] rdata_next;
	logic neg_next, pos_next, ref_next;
	logic [`NUM_CH-1:0] warn_v, trip_v;
	logic signed [15:0] mon_temp [`NUM_CH];
	logic signed [15:0] mon_warn [`NUM_CH];
	logic signed [15:0] mon_max [`NUM_CH];

	// contact evaluation of one switch
	function automatic logic sw_active(input logic [15:0] mode,
		input logic lvl);
		logic act;
		act = 1'b0;
		if (mode == `EVAL_NC)
			act = !lvl; // opened contact is active
		else if (mode == `EVAL_NO)
			act = lvl;
		return act;
	endfunction

	// two-stage synchroniser for the switch pins, running through reset
	// so that a closed contact is not seen as open just after release
	always_ff @(posedge CLOCK) begin
		sw_meta_reg <= {REFERENCE_SWITCH, POSITIVE_TRAVEL_SWITCH,
			NEGATIVE_TRAVEL_SWITCH};
		sw_sync_reg <= sw_meta_reg;
	end

	// next values of the evaluation settings
	always_comb begin
		ref_eval_next = ref_eval_reg;
		lneg_eval_next = lneg_eval_reg;
		lpos_eval_next = lpos_eval_reg;
		if (PAR_WR) begin
			case (PAR_ADDR)
				`ADDR_REF_EVAL: begin
					if (PAR_WDATA == `EVAL_NC || PAR_WDATA == `EVAL_NO)
						ref_eval_next = PAR_WDATA;
				end
				`ADDR_LNEG_EVAL: begin
					if (PAR_WDATA <= `EVAL_NO)
						lneg_eval_next = PAR_WDATA;
				end
				`ADDR_LPOS_EVAL: begin
					if (PAR_WDATA <= `EVAL_NO)
						lpos_eval_next = PAR_WDATA;
				end
				default: begin
					ref_eval_next = ref_eval_reg; // read-only or unmapped
				end
			endcase
		end
	end

	// read data, limits are constants
	always_comb begin
		rdata_next = `ZERO16;
		case (PAR_ADDR)
			`ADDR_REF_EVAL: rdata_next = ref_eval_reg;
			`ADDR_LNEG_EVAL: rdata_next = lneg_eval_reg;
			`ADDR_LPOS_EVAL: rdata_next = lpos_eval_reg;
			`ADDR_MOT_MAX: rdata_next = `MOT_MAX_T;
			`ADDR_AMP_WARN: rdata_next = `AMP_WARN_T;
			`ADDR_AMP_MAX: rdata_next = `AMP_MAX_T;
			`ADDR_AMP_NOW: rdata_next = TEMP_AMP;
			`ADDR_DEV_NOW: rdata_next = TEMP_DEVICE;
			// no value for a switching sensor
			`ADDR_MOT_NOW: rdata_next = MOTOR_SENSOR_KIND ? `ZERO16 : TEMP_MOTOR;
			default: rdata_next = `ZERO16;
		endcase
	end

	// switch results
	always_comb begin
		neg_next = sw_active(lneg_eval_reg, sw_sync_reg[`SW_NEG]);
		pos_next = sw_active(lpos_eval_reg, sw_sync_reg[`SW_POS]);
		ref_next = HOMING_TO_REF
			&& sw_active(ref_eval_reg, sw_sync_reg[`SW_REF]);
	end

	// register settings and outputs
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			ref_eval_reg <= `EVAL_RESET;
			lneg_eval_reg <= `EVAL_RESET;
			lpos_eval_reg <= `EVAL_RESET;
			PAR_RDATA <= `ZERO16;
			PAR_ACK <= 1'b0;
			NEG_LIMIT_HIT <= 1'b0;
			POS_LIMIT_HIT <= 1'b0;
			REF_HIT <= 1'b0;
			STOP_MOTOR <= 1'b0;
			TEMP_WARN <= 1'b0;
			TEMP_ERR <= 1'b0;
			AMP_OFF <= 1'b0;
			CTRL_OFF <= 1'b0;
		end else begin
			ref_eval_reg <= ref_eval_next;
			lneg_eval_reg <= lneg_eval_next;
			lpos_eval_reg <= lpos_eval_next;
			PAR_RDATA <= PAR_RD ? rdata_next : `ZERO16;
			PAR_ACK <= PAR_RD || PAR_WR;
			NEG_LIMIT_HIT <= neg_next;
			POS_LIMIT_HIT <= pos_next;
			REF_HIT <= ref_next;
			STOP_MOTOR <= neg_next || pos_next;
			TEMP_WARN <= |warn_v;
			TEMP_ERR <= |trip_v;
			AMP_OFF <= |trip_v;
			CTRL_OFF <= |trip_v;
		end
	end

	assign mon_temp[`CH_MOT] = TEMP_MOTOR;
	assign mon_temp[`CH_AMP] = TEMP_AMP;
	assign mon_temp[`CH_RES] = TEMP_RESISTOR;
	assign mon_warn[`CH_MOT] = `MOT_WARN_T;
	assign mon_warn[`CH_AMP] = `AMP_WARN_T;
	assign mon_warn[`CH_RES] = `RES_WARN_T;
	assign mon_max[`CH_MOT] = `MOT_MAX_T;
	assign mon_max[`CH_AMP] = `AMP_MAX_T;
	assign mon_max[`CH_RES] = `RES_MAX_T;

	for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
		lrtm_temp_if tif ();
		assign tif.temp = mon_temp[i];
		assign tif.warn_lim = mon_warn[i];
		assign tif.max_lim = mon_max[i];
		assign warn_v[i] = tif.warn;
		assign trip_v[i] = tif.trip;
		lrtm_temp_chan #(.OVT_CYCLES(OVT_CYCLES)) u_chan (
			.clk(CLOCK),
			.rst(RESET),
			.tch(tif.chan)
		);
	end

	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);

	AST_LIM_NC: assert property (
		(lpos_eval_reg == `EVAL_NC && !sw_sync_reg[`SW_POS])
		|=> POS_LIMIT_HIT)
		else $error("closed contact opening not seen");
	AST_LIM_OFF: assert property (
		lneg_eval_reg == `EVAL_OFF |=> !NEG_LIMIT_HIT)
		else $error("disabled limit switch reported");
	AST_REF_ZERO: assert property (
		(PAR_WR && PAR_ADDR == `ADDR_REF_EVAL && PAR_WDATA == `EVAL_OFF)
		|=> $stable(ref_eval_reg))
		else $error("reference setting took zero");
	AST_REF_GATE: assert property (
		!HOMING_TO_REF |=> !REF_HIT)
		else $error("reference seen outside homing");
	AST_STOP: assert property (
		STOP_MOTOR == (NEG_LIMIT_HIT || POS_LIMIT_HIT))
		else $error("stop does not follow limit switches");
	AST_SHUT: assert property (
		(|trip_v) |=> AMP_OFF && CTRL_OFF && TEMP_ERR)
		else $error("trip without shutdown");
	AST_ERR_HOLD: assert property (
		TEMP_ERR |=> TEMP_ERR && TEMP_WARN)
		else $error("temperature error dropped");
	AST_AMP_MAX_RD: assert property (
		(PAR_RD && PAR_ADDR == `ADDR_AMP_MAX) |=> PAR_RDATA == `AMP_MAX_T)
		else $error("amplifier limit readout wrong");
	AST_MOT_SW: assert property (
		(PAR_RD && PAR_ADDR == `ADDR_MOT_NOW && MOTOR_SENSOR_KIND)
		|=> PAR_RDATA == `ZERO16)
		else $error("switching sensor readout not zero");
	COV_REF: cover property ($rose(REF_HIT));
	COV_LIMIT: cover property ($rose(STOP_MOTOR));
	COV_WARN: cover property ($rose(TEMP_WARN) ##1 !TEMP_ERR);
endmodule

// File: tb.sv
// self-checking bench for the switch and temperature monitor
`timescale 1ns/100ps
`include "lrtm_consts.svh"
module tb;
	localparam int OVT = 8;
	logic clk = 0, rst = 1, hom = 0, wr = 0, rdq = 0, skind = 0;
	logic act_n = 0, act_p = 0, act_r = 0;
	logic [2:0] nok = 3'h0;
	logic signed [15:0] t_m = 16'sh001e, t_a = 16'sh0019;
	logic signed [15:0] t_r = 16'sh0019, t_d = 16'shfffb;
	logic [15:0] addr = 16'h0000, wdat = 16'h0000;
	wire [15:0] rdat;
	wire ack, nhit, phit, rhit, stop, warn, err, aoff, coff, pn, pp, pr;
	int failures = 0, compares = 0;
	// switch contacts on the far side
	lrtm_far_side i_far (.act_neg(act_n), .act_pos(act_p), .act_ref(act_r),
		.no_kind(nok), .neg_pin(pn), .pos_pin(pp), .ref_pin(pr));
	lrtm_top #(.OVT_CYCLES(OVT)) i_dut (.CLOCK(clk), .RESET(rst),
		.NEGATIVE_TRAVEL_SWITCH(pn), .POSITIVE_TRAVEL_SWITCH(pp),
		.REFERENCE_SWITCH(pr), .HOMING_TO_REF(hom), .TEMP_MOTOR(t_m),
		.TEMP_AMP(t_a), .TEMP_RESISTOR(t_r), .TEMP_DEVICE(t_d),
		.MOTOR_SENSOR_KIND(skind), .PAR_ADDR(addr), .PAR_WR(wr),
		.PAR_RD(rdq), .PAR_WDATA(wdat), .PAR_RDATA(rdat), .PAR_ACK(ack),
		.NEG_LIMIT_HIT(nhit), .POS_LIMIT_HIT(phit), .REF_HIT(rhit),
		.STOP_MOTOR(stop), .TEMP_WARN(warn), .TEMP_ERR(err),
		.AMP_OFF(aoff), .CTRL_OFF(coff));
	// free running clock, 4 ns
	initial forever #2 clk = ~clk;
	task chk1(input logic g, input logic e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t flag got %b exp %b", $time, g, e);
		end
	endtask
	task chk16(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t word got %h exp %h", $time, g, e);
		end
	endtask
	// one write, acknowledged one cycle later
	task wr16(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1 chk1(ack, 1'b1);
	endtask
	// one read, data valid with the acknowledge
	task rd16(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		rdq <= 1'b1;
		addr <= a;
		@(posedge clk);
		rdq <= 1'b0;
		#1 chk1(ack, 1'b1);
		chk16(rdat, e);
	endtask
	task settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task end_of_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#40000;
		failures++;
		$display("mismatch t=%0t watchdog expired", $time);
		end_of_test;
	end
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd16(`ADDR_REF_EVAL, `EVAL_RESET);
		rd16(`ADDR_LNEG_EVAL, `EVAL_RESET);
		rd16(`ADDR_LPOS_EVAL, `EVAL_RESET);
		rd16(`ADDR_MOT_MAX, `MOT_MAX_T);
		rd16(`ADDR_AMP_WARN, `AMP_WARN_T);
		wr16(`ADDR_AMP_MAX, 16'h0000);
		rd16(`ADDR_AMP_MAX, `AMP_MAX_T);
		rd16(16'h0000, 16'h0000);
		wr16(`ADDR_LNEG_EVAL, 16'h0003);
		rd16(`ADDR_LNEG_EVAL, `EVAL_NC);
		// each limit setting with a matching contact kind
		for (int s = 0; s < 3; s++) begin
			wr16(`ADDR_LNEG_EVAL, s[15:0]);
			wr16(`ADDR_LPOS_EVAL, s[15:0]);
			@(posedge clk);
			nok <= {1'b0, {2{s == 2}}};
			act_n <= 1'b0;
			settle;
			chk1(stop, 1'b0);
			@(posedge clk);
			act_p <= 1'b1;
			settle;
			chk1(phit, s != 0);
			chk1(stop, s != 0);
			@(posedge clk);
			act_p <= 1'b0;
			act_n <= 1'b1;
			settle;
			chk1(nhit, s != 0);
			chk1(phit, 1'b0);
		end
		// reference only counts while homing
		wr16(`ADDR_REF_EVAL, `EVAL_OFF);
		rd16(`ADDR_REF_EVAL, `EVAL_NC);
		wr16(`ADDR_REF_EVAL, `EVAL_NO);
		@(posedge clk);
		nok <= 3'h7;
		act_n <= 1'b0;
		act_r <= 1'b1;
		settle;
		chk1(rhit, 1'b0);
		@(posedge clk);
		hom <= 1'b1;
		settle;
		chk1(rhit, 1'b1);
		@(posedge clk);
		act_r <= 1'b0;
		settle;
		chk1(rhit, 1'b0);
		// live readouts
		rd16(`ADDR_AMP_NOW, 16'h0019);
		rd16(`ADDR_MOT_NOW, 16'h001e);
		rd16(`ADDR_DEV_NOW, 16'hfffb);
		@(posedge clk);
		skind <= 1'b1;
		t_r <= `RES_WARN_T;
		settle;
		rd16(`ADDR_MOT_NOW, 16'h0000);
		chk1(warn, 1'b1);
		chk1(err, 1'b0);
		@(posedge clk);
		t_r <= 16'sh0019;
		settle;
		chk1(warn, 1'b0);
		// motor channel warns as well
		@(posedge clk);
		t_m <= `MOT_WARN_T;
		settle;
		chk1(warn, 1'b1);
		@(posedge clk);
		t_m <= 16'sh001e;
		settle;
		chk1(warn, 1'b0);
		// over limit runs one short of the trip, then the trip
		@(posedge clk);
		t_a <= 16'sh005b;
		repeat (OVT) @(posedge clk);
		t_a <= `AMP_MAX_T;
		@(posedge clk);
		t_a <= 16'sh005b;
		repeat (OVT) @(posedge clk);
		t_a <= `AMP_MAX_T;
		settle;
		chk1(err, 1'b0);
		chk1(warn, 1'b1);
		@(posedge clk);
		t_a <= 16'sh005b;
		repeat (OVT + 1) @(posedge clk);
		t_a <= 16'sh0019;
		settle;
		chk1(err, 1'b1);
		chk1(aoff, 1'b1);
		chk1(coff, 1'b1);
		// a second reset clears the latch with no false stop after it
		@(posedge clk);
		rst <= 1'b1;
		nok <= 3'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 chk1(err, 1'b0);
		chk1(aoff, 1'b0);
		chk1(stop, 1'b0);
		rd16(`ADDR_REF_EVAL, `EVAL_RESET);
		end_of_test;
	end
endmodule
